/* design/i2cra_ctrl.sv */
// Remote addressing control: registers 0x05..0x08, remote write blocking, address remap,
// SDA output delay and the bus watchdog. Register requests come from the device's own
// serial-control slave on clk; SCL and SDA are pins and are synchronised here.
`timescale 1ns/1ps
`include "i2cra_defs.svh"

module i2cra_ctrl #(
	parameter int unsigned WD_SHORT_CYC = `I2CRA_WD_SHORT_CYC,
	parameter int unsigned WD_LONG_CYC = `I2CRA_WD_LONG_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Register access
	input i2cra_pkg::i2cra_req_t reg_req,
	output logic [7:0] reg_rdata,
	output logic reg_rd_valid,
	output logic reg_wr_reject,
	// Control channel
	input wire logic rx_lock,
	input wire logic [6:0] peer_id,
	// Local master transactions and forwarding
	input i2cra_pkg::i2cra_txn_t txn,
	output logic fwd_valid,
	output logic fwd_to_peer,
	output logic [6:0] fwd_addr,
	// Bus pins
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_release,
	output logic scl_out,
	output logic scl_oe,
	output logic sda_out,
	output logic sda_oe,
	output logic bus_free,
	output logic wd_recovering
);
	import i2cra_pkg::*;

	function automatic logic [4:0] dly_cycles(input logic [1:0] code);
		int unsigned ns;
		ns = `I2CRA_SDA_DLY_BASE_NS + `I2CRA_SDA_DLY_STEP_NS * int'(code);
		dly_cycles = 5'((ns * `I2CRA_CLK_KHZ + 999999) / 1000000);
	endfunction : dly_cycles

	logic [7:0] ctrl_reg, ctrl_next;
	logic [7:0] peer_reg, peer_next;
	logic [7:0] tgt_reg, tgt_next;
	logic [7:0] alias_reg, alias_next;
	logic [7:0] rdata_reg, rdata_next;
	logic rd_valid_reg, rd_valid_next;
	logic reject_reg, reject_next;
	logic lock_d_reg;
	logic fwd_valid_reg, fwd_valid_next;
	logic fwd_peer_reg, fwd_peer_next;
	logic [6:0] fwd_addr_reg, fwd_addr_next;
	logic scl_meta_reg, scl_s_reg, sda_meta_reg, sda_s_reg, scl_d_reg;
	logic [4:0] dly_reg, dly_next;
	logic dly_run_reg, dly_run_next;
	logic sda_rel_reg, sda_rel_next;
	logic wr_ok, autoload, scl_fall;

	assign wr_ok = reg_req.valid && reg_req.write && !(reg_req.remote && ctrl_reg[`I2CRA_CTRL_WRBLK]);
	assign autoload = rx_lock && !lock_d_reg && !peer_reg[`I2CRA_PEER_LOCK];

	always_comb begin
		ctrl_next = ctrl_reg;
		peer_next = peer_reg;
		tgt_next = tgt_reg;
		alias_next = alias_reg;
		rdata_next = rdata_reg;
		rd_valid_next = 1'b0;
		reject_next = reg_req.valid && reg_req.write && !wr_ok;
		if (autoload) begin
			peer_next = {peer_id, peer_reg[`I2CRA_PEER_LOCK]};
		end
		if (wr_ok && reg_req.addr == `I2CRA_OFS_CTRL) begin
			ctrl_next = reg_req.wdata & `I2CRA_CTRL_MASK;
		end else if (wr_ok && reg_req.addr == `I2CRA_OFS_PEER) begin
			peer_next = reg_req.wdata;
		end else if (wr_ok && reg_req.addr == `I2CRA_OFS_TGT) begin
			tgt_next = reg_req.wdata & `I2CRA_ADDR_MASK;
		end else if (wr_ok && reg_req.addr == `I2CRA_OFS_ALIAS) begin
			alias_next = reg_req.wdata & `I2CRA_ADDR_MASK;
		end
		if (reg_req.valid && !reg_req.write) begin
			rd_valid_next = 1'b1;
			if (reg_req.addr == `I2CRA_OFS_CTRL) begin
				rdata_next = ctrl_reg;
			end else if (reg_req.addr == `I2CRA_OFS_PEER) begin
				rdata_next = peer_reg;
			end else if (reg_req.addr == `I2CRA_OFS_TGT) begin
				rdata_next = tgt_reg;
			end else if (reg_req.addr == `I2CRA_OFS_ALIAS) begin
				rdata_next = alias_reg;
			end else begin
				rdata_next = 8'h00;
			end
		end
	end

	always_comb begin
		fwd_valid_next = 1'b0;
		fwd_peer_next = fwd_peer_reg;
		fwd_addr_next = fwd_addr_reg;
		if (txn.valid) begin
			if (peer_reg[7:1] != 7'h00 && txn.addr == peer_reg[7:1]) begin
				fwd_valid_next = 1'b1;
				fwd_peer_next = 1'b1;
				fwd_addr_next = peer_reg[7:1];
			end else if (alias_reg[7:1] != 7'h00 && txn.addr == alias_reg[7:1]) begin
				fwd_valid_next = 1'b1;
				fwd_peer_next = 1'b0;
				fwd_addr_next = tgt_reg[7:1];
			end
		end
	end

	assign scl_fall = scl_d_reg && !scl_s_reg;

	always_comb begin
		dly_next = dly_reg;
		dly_run_next = dly_run_reg;
		sda_rel_next = sda_rel_reg;
		if (scl_fall) begin
			dly_next = dly_cycles(ctrl_reg[`I2CRA_CTRL_DLY_HI:`I2CRA_CTRL_DLY_LO]) - 5'h01;
			dly_run_next = 1'b1;
		end else if (dly_run_reg && dly_reg != 5'h00) begin
			dly_next = dly_reg - 5'h01;
		end else if (dly_run_reg) begin
			dly_run_next = 1'b0;
			sda_rel_next = sda_release;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			ctrl_reg <= `I2CRA_RESET_VAL;
			peer_reg <= `I2CRA_RESET_VAL;
			tgt_reg <= `I2CRA_RESET_VAL;
			alias_reg <= `I2CRA_RESET_VAL;
			rdata_reg <= 8'h00;
			rd_valid_reg <= 1'b0;
			reject_reg <= 1'b0;
			lock_d_reg <= 1'b0;
			fwd_valid_reg <= 1'b0;
			fwd_peer_reg <= 1'b0;
			fwd_addr_reg <= 7'h00;
			scl_meta_reg <= 1'b1;
			scl_s_reg <= 1'b1;
			sda_meta_reg <= 1'b1;
			sda_s_reg <= 1'b1;
			scl_d_reg <= 1'b1;
			dly_reg <= 5'h00;
			dly_run_reg <= 1'b0;
			sda_rel_reg <= 1'b1;
		end else begin
			ctrl_reg <= ctrl_next;
			peer_reg <= peer_next;
			tgt_reg <= tgt_next;
			alias_reg <= alias_next;
			rdata_reg <= rdata_next;
			rd_valid_reg <= rd_valid_next;
			reject_reg <= reject_next;
			lock_d_reg <= rx_lock;
			fwd_valid_reg <= fwd_valid_next;
			fwd_peer_reg <= fwd_peer_next;
			fwd_addr_reg <= fwd_addr_next;
			scl_meta_reg <= scl_in;
			scl_s_reg <= scl_meta_reg;
			sda_meta_reg <= sda_in;
			sda_s_reg <= sda_meta_reg;
			scl_d_reg <= scl_s_reg;
			dly_reg <= dly_next;
			dly_run_reg <= dly_run_next;
			sda_rel_reg <= sda_rel_next;
		end
	end

	i2cra_watchdog #(
		.TO_SHORT(WD_SHORT_CYC),
		.TO_LONG(WD_LONG_CYC)
	) u_wd (
		.clk(clk),
		.nrst(nrst),
		.scl_s(scl_s_reg),
		.sda_s(sda_s_reg),
		.disable_wd(ctrl_reg[`I2CRA_CTRL_WDOFF]),
		.short_mode(ctrl_reg[`I2CRA_CTRL_WDSHORT]),
		.bus_free(bus_free),
		.scl_oe(scl_oe),
		.recovering(wd_recovering)
	);

	assign reg_rdata = rdata_reg;
	assign reg_rd_valid = rd_valid_reg;
	assign reg_wr_reject = reject_reg;
	assign fwd_valid = fwd_valid_reg;
	assign fwd_to_peer = fwd_peer_reg;
	assign fwd_addr = fwd_addr_reg;
	// Open drain: both lines only ever pull low
	assign scl_out = 1'b0;
	assign sda_out = 1'b0;
	assign sda_oe = !sda_rel_reg;

	sequence seq_remote_wr_blocked;
		reg_req.valid && reg_req.write && reg_req.remote && ctrl_reg[`I2CRA_CTRL_WRBLK];
	endsequence

	sequence seq_dly_code3_armed;
		dly_run_reg && dly_reg == 5'h0E;
	endsequence

	sequence seq_dly_code3_done;
		(dly_run_reg && dly_reg == 5'h00) ##1 !dly_run_reg;
	endsequence

	AST_REMOTE_BLOCK: assert property (@(posedge clk) disable iff (!nrst)
		seq_remote_wr_blocked |=> reg_wr_reject && $stable(ctrl_reg) && $stable(tgt_reg))
		else $error("blocked remote write changed a register");

	AST_LOCAL_WRITE_OK: assert property (@(posedge clk) disable iff (!nrst)
		(reg_req.valid && reg_req.write && !reg_req.remote) |=> !reg_wr_reject)
		else $error("local write was refused");

	AST_SDA_DELAY: assert property (@(posedge clk) disable iff (!nrst)
		(scl_fall && ctrl_reg[`I2CRA_CTRL_DLY_HI:`I2CRA_CTRL_DLY_LO] == 2'h3)
		|=> seq_dly_code3_armed ##14 seq_dly_code3_done)
		else $error("SDA delay for code 3 is not 15 cycles");

	AST_PEER_ZERO: assert property (@(posedge clk) disable iff (!nrst)
		(txn.valid && peer_reg[7:1] == 7'h00 && alias_reg[7:1] == 7'h00) |=> !fwd_valid)
		else $error("forwarded with both addresses zero");

	AST_AUTOLOAD: assert property (@(posedge clk) disable iff (!nrst)
		(autoload && !(reg_req.valid && reg_req.write)) |=> peer_reg[7:1] == $past(peer_id))
		else $error("peer address not loaded on lock");

	AST_LOCK_HOLDS: assert property (@(posedge clk) disable iff (!nrst)
		(peer_reg[0] && !(reg_req.valid && reg_req.write)) |=> $stable(peer_reg))
		else $error("locked peer address changed");

	AST_REMAP: assert property (@(posedge clk) disable iff (!nrst)
		(txn.valid && alias_reg[7:1] != 7'h00 && txn.addr == alias_reg[7:1] && txn.addr != peer_reg[7:1])
		|=> fwd_valid && !fwd_to_peer && fwd_addr == $past(tgt_reg[7:1]))
		else $error("alias hit not remapped to target");

	AST_RESERVED_ZERO: assert property (@(posedge clk) disable iff (!nrst)
		ctrl_reg[7:5] == 3'h0 && tgt_reg[0] == 1'b0 && alias_reg[0] == 1'b0)
		else $error("reserved bit set");

endmodule : i2cra_ctrl

/* design/i2cra_watchdog.sv */
// Bus watchdog: idle timer on the synchronised bus lines and the nine-clock recovery.
// Expects scl_s and sda_s already synchronised to clk.
`timescale 1ns/1ps
`include "i2cra_defs.svh"

module i2cra_watchdog #(
	parameter int unsigned TO_SHORT = `I2CRA_WD_SHORT_CYC,
	parameter int unsigned TO_LONG = `I2CRA_WD_LONG_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Bus view and settings
	input wire logic scl_s,
	input wire logic sda_s,
	input wire logic disable_wd,
	input wire logic short_mode,
	// Results
	output logic bus_free,
	output logic scl_oe,
	output logic recovering
);
	import i2cra_pkg::*;

	i2cra_wd_state_t state_reg, state_next;
	logic [25:0] idle_reg, idle_next;
	logic [7:0] half_reg, half_next;
	logic [3:0] pulse_reg, pulse_next;
	logic scl_d_reg, sda_d_reg;
	logic free_reg, free_next;
	logic [25:0] limit;
	logic activity;
	logic [11:0] rcv_cyc_reg, rcv_cyc_next;

	assign limit = short_mode ? 26'(TO_SHORT - 1) : 26'(TO_LONG - 1);
	assign activity = (scl_s != scl_d_reg) || (sda_s != sda_d_reg);

	always_comb begin
		state_next = state_reg;
		idle_next = idle_reg;
		half_next = half_reg;
		pulse_next = pulse_reg;
		free_next = 1'b0;
		case (state_reg)
			WD_WATCH: begin
				if (disable_wd || activity) begin
					idle_next = '0;
				end else if (idle_reg >= limit) begin
					idle_next = '0;
					if (sda_s) begin
						free_next = 1'b1;
					end else begin
						state_next = WD_LOW;
						half_next = '0;
						pulse_next = '0;
					end
				end else begin
					idle_next = idle_reg + 26'h0000001;
				end
			end
			WD_LOW: begin
				if (half_reg == 8'(`I2CRA_RCV_HALF_CYC - 1)) begin
					half_next = '0;
					state_next = WD_HIGH;
				end else begin
					half_next = half_reg + 8'h01;
				end
			end
			WD_HIGH: begin
				if (half_reg == 8'(`I2CRA_RCV_HALF_CYC - 1)) begin
					half_next = '0;
					pulse_next = pulse_reg + 4'h1;
					state_next = (pulse_reg == 4'(`I2CRA_RCV_PULSES - 1)) ? WD_WATCH : WD_LOW;
				end else begin
					half_next = half_reg + 8'h01;
				end
			end
			default: state_next = WD_WATCH;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			state_reg <= WD_WATCH;
			idle_reg <= '0;
			half_reg <= '0;
			pulse_reg <= '0;
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
			free_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			idle_reg <= idle_next;
			half_reg <= half_next;
			pulse_reg <= pulse_next;
			scl_d_reg <= scl_s;
			sda_d_reg <= sda_s;
			free_reg <= free_next;
		end
	end

	assign bus_free = free_reg;
	assign scl_oe = (state_reg == WD_LOW);
	assign recovering = (state_reg != WD_WATCH);

	// Recovery length counter, read only by the assertions; a range of delays this long would not unroll
	always_comb begin
		rcv_cyc_next = recovering ? rcv_cyc_reg + 12'h001 : 12'h000;
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			rcv_cyc_reg <= 12'h000;
		end else begin
			rcv_cyc_reg <= rcv_cyc_next;
		end
	end

	AST_RCV_ENDS: assert property (@(posedge clk) disable iff (!nrst)
		recovering |-> rcv_cyc_reg < 12'(2 * `I2CRA_RCV_HALF_CYC * `I2CRA_RCV_PULSES))
		else $error("recovery did not end after nine clocks");

	AST_RCV_LENGTH: assert property (@(posedge clk) disable iff (!nrst)
		$fell(recovering) |-> rcv_cyc_reg == 12'(2 * `I2CRA_RCV_HALF_CYC * `I2CRA_RCV_PULSES))
		else $error("recovery ended early");

	AST_WD_OFF: assert property (@(posedge clk) disable iff (!nrst)
		(disable_wd && !recovering) |=> !bus_free && !$rose(scl_oe))
		else $error("watchdog acted while disabled");

	AST_SHORT_TIMEOUT: assert property (@(posedge clk) disable iff (!nrst)
		bus_free |-> $past(idle_reg) >= ($past(short_mode) ? 26'(TO_SHORT - 1) : 26'(TO_LONG - 1)))
		else $error("bus free before the idle time ran out");

endmodule : i2cra_watchdog

/* pkg/i2cra_defs.svh */
// Offsets, field positions, reset values and timing counts of the remote addressing block.
// Included by the design files and the bench; holds definitions only.
`ifndef I2CRA_DEFS_SVH
`define I2CRA_DEFS_SVH

`define I2CRA_OFS_CTRL 8'h05
`define I2CRA_OFS_PEER 8'h06
`define I2CRA_OFS_TGT 8'h07
`define I2CRA_OFS_ALIAS 8'h08

`define I2CRA_CTRL_WDOFF 0
`define I2CRA_CTRL_WDSHORT 1
`define I2CRA_CTRL_WRBLK 2
`define I2CRA_CTRL_DLY_LO 3
`define I2CRA_CTRL_DLY_HI 4
`define I2CRA_CTRL_MASK 8'h1F
`define I2CRA_PEER_LOCK 0
`define I2CRA_ADDR_MASK 8'hFE
`define I2CRA_RESET_VAL 8'h00

`define I2CRA_CLK_KHZ 40000
`define I2CRA_SDA_DLY_BASE_NS 240
`define I2CRA_SDA_DLY_STEP_NS 40
`define I2CRA_WD_SHORT_MS 50
`define I2CRA_WD_LONG_MS 1000
`define I2CRA_WD_SHORT_CYC (`I2CRA_WD_SHORT_MS * `I2CRA_CLK_KHZ)
`define I2CRA_WD_LONG_CYC (`I2CRA_WD_LONG_MS * `I2CRA_CLK_KHZ)
`define I2CRA_RCV_HALF_NS 5000
`define I2CRA_RCV_HALF_CYC ((`I2CRA_RCV_HALF_NS * `I2CRA_CLK_KHZ) / 1000000)
`define I2CRA_RCV_PULSES 9

`endif

/* pkg/i2cra_pkg.sv */
// Types shared by the remote addressing block and its watchdog.
// Constants live in i2cra_defs.svh.
package i2cra_pkg;

	typedef struct packed {
		logic valid;
		logic write;
		logic remote;
		logic [7:0] addr;
		logic [7:0] wdata;
	} i2cra_req_t;

	typedef struct packed {
		logic valid;
		logic [6:0] addr;
	} i2cra_txn_t;

	typedef enum logic [1:0] {
		WD_WATCH,
		WD_LOW,
		WD_HIGH
	} i2cra_wd_state_t;

endpackage : i2cra_pkg

/* tb/i2cra_bus_model.sv */
// Local bus model: open-drain SCL and SDA with pull-ups and one local master.
// Assumes the design's enables mean that it pulls the line low.
`timescale 1ns/1ps

module i2cra_bus_model (
	// Design side
	input wire logic scl_oe,
	input wire logic sda_oe,
	// Master side
	input wire logic frame,
	input wire logic sda_hold,
	// Wire levels
	output logic scl_in,
	output logic sda_in
);
	logic scl_lo;

	initial scl_lo = 1'h0;
	// One 100 ns SCL low pulse per frame; SCL stands still between frames
	always @(posedge frame) begin
		#107 scl_lo = 1'h1;
		#100 scl_lo = 1'h0;
	end
	// Pull-ups: a line nobody pulls reads high
	assign scl_in = !(scl_oe || scl_lo);
	assign sda_in = !(sda_oe || sda_hold);
endmodule : i2cra_bus_model

/* tb/i2cra_ctrl_tb.sv */
// Bench for i2cra_ctrl: register map, write blocking, forwarding, autoload, SDA delay, watchdog.
// Assumes watchdog counts shortened to 50 and 100 cycles and the bus model on the pins.
`timescale 1ns/1ps
`include "i2cra_defs.svh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin miscompares++; \
$display("BAD %s exp %0h got %0h", nm, e, g); end end

module i2cra_ctrl_tb;
	import i2cra_pkg::*;
	localparam int TS = 50;
	localparam int TL = 100;
	// Offset, write data, read-back
	localparam logic [23:0] ROWS [7] = '{24'h05FF1F, 24'h06A5A5, 24'h07FFFE, 24'h08FFFE, 24'h095500,
		24'h05E000, 24'h060000};
	logic clk = 1'h0;
	logic nrst = 1'h0;
	logic rx_lock = 1'h0;
	logic sda_release = 1'h1;
	logic frame = 1'h0;
	logic sda_hold = 1'h0;
	logic [6:0] peer_id = 7'h00;
	i2cra_req_t req = '0;
	i2cra_txn_t txn = '0;
	logic [7:0] rdata, got;
	logic [6:0] fwd_addr;
	logic rd_valid, wr_rej, fwd_valid, fwd_to_peer, scl_in, sda_in, scl_out, scl_oe, sda_out, sda_oe;
	logic bus_free, wd_rec, vld, rej, fv;
	int miscompares = 0;
	int compares = 0;
	int n, c;

	i2cra_ctrl #(.WD_SHORT_CYC(TS), .WD_LONG_CYC(TL)) i_i2cra_ctrl (.clk(clk), .nrst(nrst), .reg_req(req),
		.reg_rdata(rdata), .reg_rd_valid(rd_valid), .reg_wr_reject(wr_rej), .rx_lock(rx_lock), .peer_id(peer_id),
		.txn(txn), .fwd_valid(fwd_valid), .fwd_to_peer(fwd_to_peer), .fwd_addr(fwd_addr), .scl_in(scl_in),
		.sda_in(sda_in), .sda_release(sda_release), .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out),
		.sda_oe(sda_oe), .bus_free(bus_free), .wd_recovering(wd_rec));
	i2cra_bus_model i_i2cra_bus_model (.scl_oe(scl_oe), .sda_oe(sda_oe), .frame(frame), .sda_hold(sda_hold),
		.scl_in(scl_in), .sda_in(sda_in));

	always #12.5 clk = ~clk;

	task automatic complete_run;
		if (miscompares == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : complete_run

	// A wait that used up its bound ends the run
	task automatic lim(input int k, input int b);
		if (k >= b) begin
			miscompares++;
			complete_run();
		end
	endtask : lim

	task automatic acc(input logic w, input logic rm, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#2 req = '{1'h1, w, rm, a, d};
		@(posedge clk);
		#1;
		rej = wr_rej;
		vld = rd_valid;
		got = rdata;
		#1 req.valid = 1'h0;
	endtask : acc

	task automatic rd(input logic [7:0] a);
		acc(1'h0, 1'h0, a, 8'h00);
	endtask : rd

	task automatic tx(input logic [6:0] a);
		@(posedge clk);
		#2 txn = '{1'h1, a};
		@(posedge clk);
		#1 fv = fwd_valid;
		#1 txn.valid = 1'h0;
	endtask : tx

	initial begin
		#2000000;
		miscompares++;
		complete_run();
	end

	initial begin
		repeat (3) @(posedge clk);
		#2 nrst = 1'h1;
		foreach (ROWS[i]) begin
			acc(1'h1, 1'h0, ROWS[i][23:16], ROWS[i][15:8]);
			rd(ROWS[i][23:16]);
			`CHK("reg", ROWS[i][7:0], got)
			`CHK("rd_valid", 1'h1, vld)
		end
		`CHK("open drain", 2'h0, {scl_out, sda_out})
		for (n = 5; n < 9; n++)
			acc(1'h1, 1'h0, n[7:0], 8'hFF);
		nrst = 1'h0;
		repeat (3) @(posedge clk);
		#2 nrst = 1'h1;
		for (n = 5; n < 9; n++) begin
			rd(n[7:0]);
			`CHK("reset", 8'h00, got)
		end
		// Remote writes refused only while the block bit is set
		acc(1'h1, 1'h0, 8'h05, 8'h04);
		acc(1'h1, 1'h1, 8'h07, 8'h22);
		`CHK("reject", 1'h1, rej)
		rd(8'h07);
		`CHK("blocked", 8'h00, got)
		acc(1'h1, 1'h0, 8'h05, 8'h00);
		acc(1'h1, 1'h1, 8'h07, 8'h22);
		`CHK("accept", 1'h0, rej)
		rd(8'h07);
		`CHK("remote wr", 8'h22, got)
		tx(7'h28);
		`CHK("no peer", 1'h0, fv)
		acc(1'h1, 1'h0, 8'h06, 8'h50);
		acc(1'h1, 1'h0, 8'h07, 8'h66);
		acc(1'h1, 1'h0, 8'h08, 8'h88);
		tx(7'h28);
		`CHK("peer", 9'h1A8, {fv, fwd_to_peer, fwd_addr})
		tx(7'h44);
		`CHK("remap", 9'h133, {fv, fwd_to_peer, fwd_addr})
		acc(1'h1, 1'h0, 8'h08, 8'h00);
		tx(7'h44);
		`CHK("alias off", 1'h0, fv)
		peer_id = 7'h5A;
		rx_lock = 1'h1;
		repeat (3) @(posedge clk);
		rd(8'h06);
		`CHK("autoload", 8'hB4, got)
		acc(1'h1, 1'h0, 8'h06, 8'h21);
		rx_lock = 1'h0;
		peer_id = 7'h11;
		@(posedge clk);
		#2 rx_lock = 1'h1;
		repeat (3) @(posedge clk);
		rd(8'h06);
		`CHK("locked", 8'h21, got)
		// SDA delay per code, watchdog off so the held line is not recovered
		for (c = 0; c < 4; c++) begin
			acc(1'h1, 1'h0, 8'h05, {3'h0, c[1:0], 3'h1});
			sda_release = c[0];
			frame = 1'h1;
			@(negedge scl_in);
			frame = 1'h0;
			n = 0;
			while (sda_oe !== !c[0] && n < 40) begin
				@(posedge clk);
				#1 n++;
			end
			lim(n, 40);
			`CHK("delay", 1'h1, n >= (264 + 40 * c) / 25 + 3 && n <= (264 + 40 * c) / 25 + 4)
		end
		for (c = 0; c < 3; c++) begin
			acc(1'h1, 1'h0, 8'h05, (c == 2) ? 8'h01 : {6'h00, c[0], 1'h0});
			frame = 1'h1;
			@(posedge scl_in);
			frame = 1'h0;
			n = 0;
			while (bus_free !== 1'h1 && n < 300) begin
				@(posedge clk);
				#1 n++;
			end
			if (c == 2)
				`CHK("wd off", 300, n)
			else
				`CHK("idle free", 1'h1, n >= (c ? TS : TL) && n <= (c ? TS : TL) + 6)
		end
		acc(1'h1, 1'h0, 8'h05, 8'h02);
		sda_hold = 1'h1;
		n = 0;
		while (wd_rec !== 1'h1 && n < 300) begin
			@(posedge clk);
			#1 n++;
		end
		lim(n, 300);
		n = 0;
		c = 0;
		// Count each cycle with SCL pulled low once, the first low phase included
		while (wd_rec === 1'h1 && c < 5000) begin
			if (scl_oe === 1'h1)
				n++;
			@(posedge clk);
			#1 c++;
		end
		lim(c, 5000);
		#1 sda_hold = 1'h0;
		`CHK("recovery", 9 * `I2CRA_RCV_HALF_CYC, n)
		complete_run();
	end
endmodule : i2cra_ctrl_tb
